// [common/arfis_regs.svh]
`ifndef ARFIS_REGS_SVH
`define ARFIS_REGS_SVH

// Byte offsets on the register bus
`define ARFIS_OFF_INSEL   8'h00
`define ARFIS_OFF_RES_LO  8'h04
`define ARFIS_OFF_RES_HI  8'h08
`define ARFIS_OFF_IRQ_STS 8'h0c
`define ARFIS_OFF_IRQ_CLR 8'h10
`define ARFIS_OFF_IRQ_EN  8'h14
`define ARFIS_OFF_STATE   8'h18

// Input-select register reset value and writable bits (bit 4 unused)
`define ARFIS_INSEL_RST   8'h00
`define ARFIS_INSEL_MASK  8'hef

// Event bit positions in status, clear and enable registers, and the status and enable reset value
`define ARFIS_EV_DONE     0
`define ARFIS_EV_OVR      1
`define ARFIS_EV_RST      2'h0

// State register bit positions
`define ARFIS_ST_BUSY     0
`define ARFIS_ST_LOCK     1
`define ARFIS_ST_DIFF     2
`define ARFIS_ST_SIGN     3

// Result reset value
`define ARFIS_RES_RST     10'h000

`endif

// [common/arfis_pkg.sv]
package arfis_pkg;

  // Reference source codes
  typedef enum logic [1:0] {
    REF_EXT_PIN = 2'b00,
    REF_SUPPLY  = 2'b01,
    REF_RSVD    = 2'b10,
    REF_INT     = 2'b11
  } arfis_ref_t;

  // Conversion tracking states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } arfis_state_t;

  // Input-select register layout
  typedef struct packed {
    arfis_ref_t ref_sel;
    logic       left_adjust;
    logic       unused;
    logic [3:0] channel;
  } arfis_insel_t;

  // Captured bus address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } arfis_aphase_t;

endpackage : arfis_pkg

// [src/arfis_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "arfis_regs.svh"

// How it works
// - A single-ended result is kept as an unsigned 10-bit code, 0x000 ground and 0x3ff full reference.
// - A differential result is kept as a 10-bit two's complement code from 0x200 up to 0x1ff.
// - Result bit 9 tells the polarity of a differential result, one meaning negative.
// - The stored result is split into a high byte and a low byte register.
// - A new result is readable in the byte registers once the conversion ends and the done flag rises.
// - The reference field codes external pin, analog supply, reserved and internal reference.
// - A reference written during a conversion takes effect only when that conversion completes.
// - The internal reference is switched on when selected and an analog feature needs it.
// - The left-adjust bit picks left justification when set and right when clear.
// - A change of the left-adjust bit re-maps the byte registers at once, mid-conversion or not.
// - The input-select register holds reference, left-adjust, an unused bit 4 and channel, reset zero.
// - Reading the low byte blocks result updates until the high byte has been read.
// - The 4-bit channel field picks inputs 0 to 10, amplifiers, reserved, bandgap or ground.
module arfis_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Converter core
  input  wire logic        conv_start,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_code,
  input  wire logic        conv_differential,
  input  wire logic        analog_need,
  // Selection applied to the analog side
  output logic [1:0]       ref_applied,
  output logic [3:0]       channel_applied,
  output logic             int_ref_on,
  // Interrupt
  output logic             irq
);

  // Bus capture and register state
  arfis_pkg::arfis_aphase_t ap_r, ap_nxt;
  arfis_pkg::arfis_insel_t  insel_r, insel_nxt;
  arfis_pkg::arfis_insel_t  appl_r, appl_nxt;
  arfis_pkg::arfis_state_t  state_r, state_nxt;
  logic [9:0]               res_r, res_nxt;
  logic                     diff_r, diff_nxt;
  logic                     lock_r, lock_nxt;
  logic [1:0]               sts_r, sts_nxt;
  logic [1:0]               en_r, en_nxt;
  logic [31:0]              rdata_r, rdata_nxt;
  logic [1:0]               ev;
  logic [1:0]               clr;
  logic [7:0]               hi_byte;
  logic [7:0]               lo_byte;
  logic                     take;
  logic                     done_ev;
  logic                     wr_ok;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign take      = hsel && hready && htrans[1];
  assign wr_ok     = ap_r.valid && ap_r.write;
  assign done_ev   = conv_done && (state_r == arfis_pkg::ST_CONV);

  // Byte mapping follows the live left-adjust bit
  always_comb begin
    if (insel_r.left_adjust) begin
      hi_byte = res_r[9:2];
      lo_byte = {res_r[1:0], 6'h00};
    end else begin
      hi_byte = {6'h00, res_r[9:8]};
      lo_byte = res_r[7:0];
    end
  end

  // Register writes, events and clears
  always_comb begin
    insel_nxt = insel_r;
    en_nxt    = en_r;
    clr       = 2'h0;
    if (wr_ok && ap_r.addr == `ARFIS_OFF_INSEL) begin
      insel_nxt = hwdata[7:0] & `ARFIS_INSEL_MASK;
    end
    if (wr_ok && ap_r.addr == `ARFIS_OFF_IRQ_EN) begin
      en_nxt = hwdata[1:0];
    end
    if (wr_ok && ap_r.addr == `ARFIS_OFF_IRQ_CLR) begin
      clr = hwdata[1:0];
    end
    ev                = 2'h0;
    ev[`ARFIS_EV_DONE] = done_ev;
    ev[`ARFIS_EV_OVR]  = done_ev && lock_r;
    sts_nxt = (sts_r & ~clr) | ev;                   // Set beats clear
  end

  // Conversion tracking, selection hand-over and result capture
  always_comb begin
    state_nxt = state_r;
    appl_nxt  = appl_r;
    res_nxt   = res_r;
    diff_nxt  = diff_r;
    lock_nxt  = lock_r;
    case (state_r)
      arfis_pkg::ST_IDLE: begin
        appl_nxt = insel_r;                          // Follows register while idle
        if (conv_start) begin
          state_nxt = arfis_pkg::ST_CONV;
        end
      end
      arfis_pkg::ST_CONV: begin
        if (conv_done) begin
          state_nxt = arfis_pkg::ST_IDLE;
          appl_nxt  = insel_r;
          if (!lock_r) begin
            res_nxt  = conv_code;
            diff_nxt = conv_differential;
          end
        end
      end
      default: begin
        state_nxt = arfis_pkg::ST_IDLE;
      end
    endcase
    // Low-byte read locks, high-byte read releases
    if (take && !hwrite && haddr[7:0] == `ARFIS_OFF_RES_LO) begin
      lock_nxt = 1'b1;
    end else if (take && !hwrite && haddr[7:0] == `ARFIS_OFF_RES_HI) begin
      lock_nxt = 1'b0;
    end
  end

  // Address phase capture and read data
  always_comb begin
    ap_nxt.valid = take;
    ap_nxt.write = hwrite;
    ap_nxt.addr  = haddr[7:0];
    rdata_nxt    = rdata_r;
    if (take && !hwrite) begin
      rdata_nxt = 32'h0000_0000;
      case (haddr[7:0])
        `ARFIS_OFF_INSEL:   rdata_nxt[7:0] = insel_r;
        `ARFIS_OFF_RES_LO:  rdata_nxt[7:0] = lo_byte;
        `ARFIS_OFF_RES_HI:  rdata_nxt[7:0] = hi_byte;
        `ARFIS_OFF_IRQ_STS: rdata_nxt[1:0] = sts_r;
        `ARFIS_OFF_IRQ_EN:  rdata_nxt[1:0] = en_r;
        `ARFIS_OFF_STATE: begin
          rdata_nxt[`ARFIS_ST_BUSY] = (state_r == arfis_pkg::ST_CONV);
          rdata_nxt[`ARFIS_ST_LOCK] = lock_r;
          rdata_nxt[`ARFIS_ST_DIFF] = diff_r;
          rdata_nxt[`ARFIS_ST_SIGN] = diff_r && res_r[9];
        end
        default:            rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r    <= '0;
      insel_r <= `ARFIS_INSEL_RST;
      appl_r  <= `ARFIS_INSEL_RST;
      state_r <= arfis_pkg::ST_IDLE;
      res_r   <= `ARFIS_RES_RST;
      diff_r  <= 1'b0;
      lock_r  <= 1'b0;
      sts_r   <= `ARFIS_EV_RST;
      en_r    <= `ARFIS_EV_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      ap_r    <= ap_nxt;
      insel_r <= insel_nxt;
      appl_r  <= appl_nxt;
      state_r <= state_nxt;
      res_r   <= res_nxt;
      diff_r  <= diff_nxt;
      lock_r  <= lock_nxt;
      sts_r   <= sts_nxt;
      en_r    <= en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs to the analog side and interrupt
  assign ref_applied     = appl_r.ref_sel;
  assign channel_applied = appl_r.channel;
  assign int_ref_on      = (appl_r.ref_sel == arfis_pkg::REF_INT) && analog_need;
  assign irq             = |(sts_r & en_r);

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_lo_read;
    take && !hwrite && haddr[7:0] == `ARFIS_OFF_RES_LO;
  endsequence

  sequence s_done_locked;
    lock_r && done_ev;
  endsequence

  a_done_sets_flag: assert property (done_ev |=> sts_r[`ARFIS_EV_DONE])
    else $error("done flag not set after completion");

  a_result_stored: assert property (done_ev && !lock_r |=> res_r == $past(conv_code))
    else $error("result not stored at completion");

  a_lock_after_lo: assert property (s_lo_read |=> lock_r)
    else $error("low byte read did not lock");

  a_lock_blocks: assert property (s_done_locked |=> res_r == $past(res_r) && sts_r[`ARFIS_EV_OVR])
    else $error("locked result was overwritten");

  a_ref_held: assert property (state_r == arfis_pkg::ST_CONV && !conv_done |=> $stable(appl_r))
    else $error("selection changed mid-conversion");

  a_ref_at_done: assert property (done_ev |=> ref_applied == $past(insel_r.ref_sel))
    else $error("new reference not applied at completion");

  a_left_map: assert property (insel_r.left_adjust |-> hi_byte == res_r[9:2] && lo_byte[5:0] == 6'h00)
    else $error("left adjust mapping wrong");

  a_right_map: assert property (!insel_r.left_adjust |-> hi_byte[7:2] == 6'h00 && lo_byte == res_r[7:0])
    else $error("right adjust mapping wrong");

  a_int_ref_on: assert property (ref_applied == 2'b11 && analog_need |-> int_ref_on)
    else $error("internal reference not switched on");

  a_unused_zero: assert property (insel_r.unused == 1'b0 ##1 insel_r.unused == 1'b0)
    else $error("unused select bit set");

  // Read path, register write and hand-over checks
  sequence s_hi_read;
    take && !hwrite && haddr[7:0] == `ARFIS_OFF_RES_HI;
  endsequence

  sequence s_insel_wr;
    wr_ok && ap_r.addr == `ARFIS_OFF_INSEL;
  endsequence

  sequence s_insel_read;
    take && !hwrite && haddr[7:0] == `ARFIS_OFF_INSEL;
  endsequence

  sequence s_state_read;
    take && !hwrite && haddr[7:0] == `ARFIS_OFF_STATE;
  endsequence

  a_unlock_hi: assert property (s_hi_read |=> !lock_r)
    else $error("high byte read did not unlock");

  a_lock_holds: assert property (lock_r && !(take && !hwrite && haddr[7:0] == `ARFIS_OFF_RES_HI) |=> lock_r)
    else $error("lock dropped without high byte read");

  a_insel_write: assert property (s_insel_wr |=>
      insel_r.unused == 1'b0 && insel_r.channel == $past(hwdata[3:0]) &&
      insel_r.left_adjust == $past(hwdata[5]) && insel_r.ref_sel == $past(hwdata[7:6]))
    else $error("select register write wrong");

  a_rd_insel: assert property (s_insel_read |=> hrdata[7:0] == $past(insel_r))
    else $error("select register read wrong");

  a_idle_follow: assert property (state_r == arfis_pkg::ST_IDLE |=> appl_r == $past(insel_r))
    else $error("applied selection not following while idle");

  a_start_busy: assert property (state_r == arfis_pkg::ST_IDLE && conv_start |=> state_r == arfis_pkg::ST_CONV)
    else $error("conversion start not tracked");

  a_int_ref_off: assert property (!(ref_applied == arfis_pkg::REF_INT && analog_need) |-> !int_ref_on)
    else $error("internal reference on without need");

  a_rd_lo: assert property (s_lo_read |=> hrdata[7:0] == $past(lo_byte))
    else $error("low byte read data wrong");

  a_rd_hi: assert property (s_hi_read |=> hrdata[7:0] == $past(hi_byte))
    else $error("high byte read data wrong");

  a_sign_bit: assert property (s_state_read |=> hrdata[`ARFIS_ST_SIGN] == ($past(diff_r) && $past(res_r[9])))
    else $error("sign bit read wrong");

  a_diff_stored: assert property (done_ev && !lock_r |=> diff_r == $past(conv_differential))
    else $error("differential mark not stored");

  a_chan_at_done: assert property (done_ev |=> channel_applied == $past(insel_r.channel))
    else $error("new channel not applied at completion");

  // Clear without a coincident event drops the done flag
  a_clear_works: assert property (wr_ok && ap_r.addr == `ARFIS_OFF_IRQ_CLR && hwdata[`ARFIS_EV_DONE] && !done_ev
      |=> !sts_r[`ARFIS_EV_DONE])
    else $error("done flag not cleared");

endmodule : arfis_top

`default_nettype wire

// [test/adc_result_format_and_input_select_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "arfis_regs.svh"

module adc_result_format_and_input_select_tb;
  // Bus, converter and selection signals
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        conv_start, conv_done, conv_differential, analog_need, int_ref_on;
  logic [1:0]  htrans, ref_applied;
  logic [2:0]  hsize;
  logic [3:0]  channel_applied;
  logic [9:0]  conv_code;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fails, n_checks, cyc;

  arfis_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code),
    .conv_differential(conv_differential), .analog_need(analog_need), .ref_applied(ref_applied),
    .channel_applied(channel_applied), .int_ref_on(int_ref_on), .irq(irq)
  );

  // Free-running clock at 40 ns
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single AHB-Lite transfer, then two idle cycles
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    hwdata <= ~wd;
    repeat (2) @(posedge hclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, rd);
    chk(nm, exp, rd);
  endtask : rchk

  // Converter core pulses
  task automatic c_start();
    conv_start <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    @(posedge hclk);
  endtask : c_start

  task automatic c_end(input logic [9:0] code, input logic diff);
    conv_done         <= 1'b1;
    conv_code         <= code;
    conv_differential <= diff;
    @(posedge hclk);
    conv_done         <= 1'b0;
    conv_code         <= ~code;
    conv_differential <= ~diff;
    repeat (2) @(posedge hclk);
  endtask : c_end

  // Main sequence
  initial begin
    {hsel, hwrite, conv_start, conv_done, conv_differential, analog_need} = 6'h00;
    {htrans, haddr, hwdata, conv_code} = '0;
    hsize    = 3'b010;
    hresetn  = 1'b0;
    fails    = 0;
    n_checks = 0;
    cyc      = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("insel reset", `ARFIS_OFF_INSEL, 32'h00000000);
    chk("applied reset", 32'h0, {ref_applied, channel_applied, irq, hresp});
    rchk("unmapped", 8'h1c, 32'h00000000);
    chk("bus okay", 32'h2, {hreadyout, hresp});
    // Every reference and channel code, unused bit written high
    for (int i = 0; i < 16; i++) begin
      wr(`ARFIS_OFF_INSEL, {24'h0, i[1:0], 2'b01, i[3:0]});
      rchk("insel", `ARFIS_OFF_INSEL, {24'h0, i[1:0], 2'b00, i[3:0]});
      chk("ref applied", i[1:0], ref_applied);
      chk("channel applied", i[3:0], channel_applied);
    end
    // Internal reference switch-on follows need, then a new reference selection turns it off
    analog_need <= 1'b1;
    @(posedge hclk);
    chk("int ref on", 1, int_ref_on);
    wr(`ARFIS_OFF_INSEL, 32'h00000042);
    chk("int ref off", 0, int_ref_on);
    // Reference change in mid-conversion is deferred
    c_start();
    wr(`ARFIS_OFF_INSEL, 32'h000000c5);
    chk("ref held", 1, ref_applied);
    chk("channel held", 2, channel_applied);
    wr(`ARFIS_OFF_IRQ_EN, 32'h00000001);
    c_end(10'h3ff, 1'b0);
    chk("ref after done", 3, ref_applied);
    chk("channel after done", 5, channel_applied);
    chk("int ref on again", 1, int_ref_on);
    chk("irq on done", 1, irq);
    rchk("full scale low", `ARFIS_OFF_RES_LO, 32'h000000ff);
    rchk("full scale high", `ARFIS_OFF_RES_HI, 32'h00000003);
    rchk("single sign", `ARFIS_OFF_STATE, 32'h00000000);
    wr(`ARFIS_OFF_INSEL, 32'h000000e5);
    rchk("left high", `ARFIS_OFF_RES_HI, 32'h000000ff);
    rchk("left low", `ARFIS_OFF_RES_LO, 32'h000000c0);
    rchk("unlock", `ARFIS_OFF_RES_HI, 32'h000000ff);
    // Interrupt mask and clear
    rchk("status done", `ARFIS_OFF_IRQ_STS, 32'h00000001);
    wr(`ARFIS_OFF_IRQ_EN, 32'h00000000);
    chk("irq masked", 0, irq);
    wr(`ARFIS_OFF_IRQ_EN, 32'h00000001);
    wr(`ARFIS_OFF_IRQ_CLR, 32'h00000003);
    chk("irq cleared", 0, irq);
    rchk("status clear", `ARFIS_OFF_IRQ_STS, 32'h00000000);
    // Differential negative and positive codes, re-mapped while converting
    c_start();
    c_end(10'h270, 1'b1);
    rchk("diff left high", `ARFIS_OFF_RES_HI, 32'h0000009c);
    rchk("diff sign", `ARFIS_OFF_STATE, 32'h0000000c);
    c_start();
    wr(`ARFIS_OFF_INSEL, 32'h000000c5);
    rchk("diff right low", `ARFIS_OFF_RES_LO, 32'h00000070);
    rchk("diff right high", `ARFIS_OFF_RES_HI, 32'h00000002);
    c_end(10'h029, 1'b1);
    rchk("small diff low", `ARFIS_OFF_RES_LO, 32'h00000029);
    rchk("small diff high", `ARFIS_OFF_RES_HI, 32'h00000000);
    // Low-byte read blocks the next result until the high byte is read
    c_start();
    c_end(10'h155, 1'b0);
    rchk("lock low", `ARFIS_OFF_RES_LO, 32'h00000055);
    c_start();
    c_end(10'h2aa, 1'b0);
    rchk("locked high", `ARFIS_OFF_RES_HI, 32'h00000001);
    rchk("overrun", `ARFIS_OFF_IRQ_STS, 32'h00000003);
    c_start();
    c_end(10'h2aa, 1'b0);
    rchk("fresh low", `ARFIS_OFF_RES_LO, 32'h000000aa);
    rchk("fresh high", `ARFIS_OFF_RES_HI, 32'h00000002);
    tally_and_finish();
  end
endmodule : adc_result_format_and_input_select_tb
`default_nettype wire
